// ### itss_dev.sv
// timer slave end of the two-wire link, with setting register
`timescale 1ns/1ns
// Overview of operation
// - start begins access, stop ends to standby
// - data change while clock high aborts transfer
// - ninth clock carries acknowledge from receiver
// - first byte is address 0110010 plus direction
// - direction zero writes, one reads
// - bytes go msb first, received bytes acknowledged
// - master acks reads, nacks last, then stops
// - repeated start takes new address, access continues
// - counter read gives three bytes msb first
// - reads past counter bytes return all ones
// - write second byte dummy, test bit one
// - third byte and bits 7..6 store selects
// - clear code 010 clears seconds counter
// - register written byte by byte, two-byte units
// - dummy byte bit 7 is address pointer
// - setting read only while gate input high
// - reads past setting bytes return all ones
// - stop resets pointer back to counter
// - selected frequencies anded into output waveform
// - clear code byte stores select bits 7..6, leaves bits 4..3 unchanged
module itss_dev
	import itss_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic NRST,
	input wire logic OUTPUT_GATE,
	input wire logic [23:0] COUNT_VALUE,
	input wire logic [9:0] DIV_TAPS,
	output logic [9:0] INTERVAL_SELECT,
	output logic TIMER_CLEAR,
	output logic INTERVAL_OUT,
	itss_if.dev BUS
);
	// ========================================
	// read byte selection
	function automatic logic [7:0] itss_rd_byte(
		input logic ptr,
		input logic gate,
		input logic [2:0] idx,
		input logic [15:0] set,
		input logic [23:0] cnt
	);
		logic [7:0] r;
		r = ITSS_FILL_BYTE;
		if (ptr == ITSS_PTR_SET && gate) begin
			if (idx == 3'h0) begin
				r = set[15:8];
			end else if (idx == ITSS_SET_LAST) begin
				r = set[7:0];
			end
		end else begin
			if (idx == 3'h0) begin
				r = cnt[23:16];
			end else if (idx == 3'h1) begin
				r = cnt[15:8];
			end else if (idx == ITSS_CNT_LAST) begin
				r = cnt[7:0];
			end
		end
		return r;
	endfunction

	// ========================================
	// pin synchronisers
	logic [2:0] scl_s, sda_s, gate_s;
	logic scl_f, sda_f, gate_f, scl_p, sda_p;

	// three stages, level taken once stages two and three agree
	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			scl_s <= 3'h7;
			sda_s <= 3'h7;
			gate_s <= 3'h0;
			scl_f <= 1'b1;
			sda_f <= 1'b1;
			gate_f <= 1'b0;
			scl_p <= 1'b1;
			sda_p <= 1'b1;
		end else begin
			scl_s <= {scl_s[1:0], BUS.scl};
			sda_s <= {sda_s[1:0], BUS.sda};
			gate_s <= {gate_s[1:0], OUTPUT_GATE};
			if (scl_s[1] == scl_s[2]) scl_f <= scl_s[2];
			if (sda_s[1] == sda_s[2]) sda_f <= sda_s[2];
			if (gate_s[1] == gate_s[2]) gate_f <= gate_s[2];
			scl_p <= scl_f;
			sda_p <= sda_f;
		end
	end

	// ========================================
	// bus events
	logic scl_rise, scl_fall, start_ev, stop_ev;
	logic byte_done, ack_done, addr_hit;

	assign scl_rise = scl_f & ~scl_p;
	assign scl_fall = ~scl_f & scl_p;
	assign start_ev = scl_f & scl_p & sda_p & ~sda_f;
	assign stop_ev = scl_f & scl_p & ~sda_p & sda_f;

	// ========================================
	// protocol state machine
	itss_dst_t state_q;
	logic [3:0] bitcnt_q;
	logic [7:0] shift_q;
	logic [2:0] idx_q;
	logic [2:0] idx_nx;
	logic drv_q;
	logic rd_q;
	logic mack_q;
	logic ptr_q;
	logic [15:0] set_q;
	logic [23:0] snap_q;
	logic [2:0] rd_idx;
	logic [7:0] rd_nx;

	assign byte_done = scl_fall && bitcnt_q == ITSS_BIT_LAST;
	assign ack_done = scl_fall && bitcnt_q == ITSS_ACK_LAST;
	assign addr_hit = shift_q[7:1] == ITSS_SLAVE_ADDR;
	assign idx_nx = (idx_q == 3'h7) ? idx_q : idx_q + 3'h1;
	// next read byte: first after address ack, then one per master ack
	assign rd_idx = (state_q == D_ADDR) ? 3'h0 : idx_nx;
	assign rd_nx = itss_rd_byte(ptr_q, gate_f, rd_idx, set_q, snap_q);

	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			state_q <= D_IDLE;
			bitcnt_q <= 4'h0;
			shift_q <= 8'h00;
			idx_q <= 3'h0;
			drv_q <= 1'b0;
			rd_q <= 1'b0;
			mack_q <= 1'b0;
		end else if (stop_ev) begin
			state_q <= D_IDLE;
			drv_q <= 1'b0;
		end else if (start_ev) begin
			state_q <= D_ADDR;
			bitcnt_q <= 4'h0;
			drv_q <= 1'b0;
		end else if (state_q != D_IDLE) begin
			if (scl_rise) begin
				if (bitcnt_q != ITSS_ACK_LAST) begin
					bitcnt_q <= bitcnt_q + 4'h1;
				end
				if (bitcnt_q < ITSS_BIT_LAST && state_q != D_READ) begin
					shift_q <= {shift_q[6:0], sda_f};
				end
				if (bitcnt_q == ITSS_BIT_LAST) begin
					mack_q <= ~sda_f;
				end
			end
			if (scl_fall && state_q == D_READ && bitcnt_q != 4'h0 &&
				bitcnt_q < ITSS_BIT_LAST) begin
				shift_q <= {shift_q[6:0], 1'b1};
				drv_q <= ~shift_q[6];
			end
			if (byte_done) begin
				case (state_q)
					D_ADDR: begin
						if (addr_hit) begin
							drv_q <= 1'b1;
							rd_q <= shift_q[0];
						end else begin
							state_q <= D_IDLE;
						end
					end
					D_WRITE: drv_q <= 1'b1;
					default: drv_q <= 1'b0;
				endcase
			end
			if (ack_done) begin
				bitcnt_q <= 4'h0;
				drv_q <= 1'b0;
				case (state_q)
					D_ADDR: begin
						idx_q <= 3'h0;
						if (rd_q) begin
							state_q <= D_READ;
							shift_q <= rd_nx;
							drv_q <= ~rd_nx[7];
						end else begin
							state_q <= D_WRITE;
						end
					end
					D_WRITE: idx_q <= idx_nx;
					D_READ: begin
						if (mack_q) begin
							idx_q <= idx_nx;
							shift_q <= rd_nx;
							drv_q <= ~rd_nx[7];
						end else begin
							state_q <= D_IDLE;
						end
					end
					default: state_q <= D_IDLE;
				endcase
			end
		end
	end

	// ========================================
	// pointer, snapshot and setting register
	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			ptr_q <= ITSS_PTR_CNT;
			set_q <= ITSS_SET_RST;
			snap_q <= ITSS_SNAP_RST;
			TIMER_CLEAR <= 1'b0;
		end else begin
			TIMER_CLEAR <= 1'b0;
			if (stop_ev) begin
				ptr_q <= ITSS_PTR_CNT;
			end else if (byte_done && state_q == D_ADDR && addr_hit) begin
				// counter captured whole for the read
				snap_q <= COUNT_VALUE;
			end else if (byte_done && state_q == D_WRITE) begin
				if (idx_q == 3'h0) begin
					ptr_q <= shift_q[ITSS_PTR_BIT];
				end else if (idx_q == 3'h1) begin
					set_q[15:8] <= shift_q;
				end else if (idx_q == 3'h2) begin
					set_q[7:5] <= shift_q[7:5];
					set_q[2:0] <= shift_q[2:0];
					TIMER_CLEAR <= shift_q[2:0] == ITSS_CLR_CODE;
				end
			end
		end
	end

	// ========================================
	// interval waveform
	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			INTERVAL_OUT <= 1'b0;
		end else if (!gate_f) begin
			INTERVAL_OUT <= 1'b1;
		end else begin
			INTERVAL_OUT <= (set_q[15:6] != 10'h000) &&
				(&(DIV_TAPS | ~set_q[15:6]));
		end
	end

	assign INTERVAL_SELECT = set_q[15:6];
	assign BUS.sda_dev_o = 1'b0;
	assign BUS.sda_dev_oe_n = ~drv_q;
endmodule

// ### itss_host.sv
// controller end of the two-wire link with an avalon-mm register port
//
// Local design decisions: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module itss_host
	import itss_pkg::*;
#(
	parameter int QTR_CYC = ITSS_QTR_CYC
)
(
	input wire logic CLK_SYS,
	input wire logic NRST,
	input wire logic [2:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	itss_if.host BUS
);
	if (QTR_CYC < 8 || QTR_CYC > 65535) begin : g_chk
		$error("QTR_CYC out of range");
	end

	// ========================================
	// transfer sequence per operation
	function automatic itss_step_t itss_item(
		input itss_op_t op,
		input logic [3:0] step,
		input logic [15:0] d
	);
		itss_step_t r;
		logic rd;
		logic [3:0] nak_step;
		rd = op != OP_WRITE;
		// data bit 0 on a read asks for one byte past the register
		nak_step = (op == OP_RCNT) ? 4'h4 : 4'h6;
		if (rd && d[0]) nak_step = nak_step + 4'h1;
		r.kind = IT_STOP;
		r.val = ITSS_FILL_BYTE;
		if (step == 4'h0 || (op == OP_RSET && step == 4'h3)) begin
			r.kind = IT_START;
		end else if (step == 4'h1 || (op == OP_RSET && step == 4'h4)) begin
			r.kind = IT_WR;
			// data bit 1 on a read aims at a foreign address
			r.val = {ITSS_SLAVE_ADDR ^ {6'h00, rd && d[1]},
				rd && step != 4'h1 || op == OP_RCNT};
		end else if (op == OP_WRITE && step < 4'h5) begin
			r.kind = IT_WR;
			r.val = (step == 4'h2) ? ITSS_DUMMY_CNT :
				(step == 4'h3) ? d[15:8] : d[7:0];
		end else if (op == OP_RSET && step == 4'h2) begin
			r.kind = IT_WR;
			r.val = ITSS_DUMMY_SET;
		end else if (rd && step < nak_step) begin
			r.kind = IT_RDACK;
		end else if (rd && step == nak_step) begin
			r.kind = IT_RDNAK;
		end
		return r;
	endfunction

	// ========================================
	// data line synchroniser
	logic [2:0] sda_s;
	logic sda_f;

	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			sda_s <= 3'h7;
			sda_f <= 1'b1;
		end else begin
			sda_s <= {sda_s[1:0], BUS.sda};
			if (sda_s[1] == sda_s[2]) begin
				sda_f <= sda_s[2];
			end
		end
	end

	// ========================================
	// quarter bit tick
	logic [15:0] qcnt_q;
	logic tick;

	assign tick = qcnt_q == 16'(QTR_CYC - 1);
	always_ff @(posedge CLK_SYS) begin
		if (!NRST || tick) begin
			qcnt_q <= 16'h0000;
		end else begin
			qcnt_q <= qcnt_q + 16'h0001;
		end
	end

	// ========================================
	// bus slave access
	logic acc;
	logic cmd_go;
	itss_hst_t st_q;
	itss_op_t op_q;
	itss_step_t it;
	logic [15:0] data_q;
	logic [23:0] rdata_q;
	logic nack_q;
	logic [3:0] step_q;
	logic [3:0] bit_q;
	logic [1:0] ph_q;
	logic [7:0] sh_q;
	logic rdm_q;
	logic ackd_q;
	logic scl_q;
	logic sdo_q;

	assign acc = (AVS_READ | AVS_WRITE) & AVS_WAITREQUEST;
	assign cmd_go = acc && AVS_WRITE && AVS_ADDRESS == ITSS_REG_CMD &&
		st_q == H_IDLE && AVS_WRITEDATA[1:0] != 2'b11;
	assign it = itss_item(op_q, step_q, data_q);

	// one wait cycle, then answer
	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA <= 32'h0000_0000;
			data_q <= 16'h0000;
		end else if (acc) begin
			AVS_WAITREQUEST <= 1'b0;
			if (AVS_WRITE && AVS_ADDRESS == ITSS_REG_DATA) begin
				data_q <= AVS_WRITEDATA[15:0];
			end
			if (AVS_ADDRESS == ITSS_REG_CMD) begin
				AVS_READDATA <= {30'h0000_0000, op_q};
			end else if (AVS_ADDRESS == ITSS_REG_DATA) begin
				AVS_READDATA <= {16'h0000, data_q};
			end else if (AVS_ADDRESS == ITSS_REG_STAT) begin
				AVS_READDATA <= {30'h0000_0000, nack_q, st_q != H_IDLE};
			end else if (AVS_ADDRESS == ITSS_REG_RDATA) begin
				AVS_READDATA <= {8'h00, rdata_q};
			end else begin
				AVS_READDATA <= 32'h0000_0000;
			end
		end else begin
			AVS_WAITREQUEST <= 1'b1;
		end
	end

	// ========================================
	// serial engine
	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			st_q <= H_IDLE;
			op_q <= OP_WRITE;
			rdata_q <= 24'h00_0000;
			nack_q <= 1'b0;
			step_q <= 4'h0;
			bit_q <= 4'h0;
			ph_q <= 2'h0;
			sh_q <= 8'hff;
			rdm_q <= 1'b0;
			ackd_q <= 1'b0;
			scl_q <= 1'b1;
			sdo_q <= 1'b1;
		end else if (st_q == H_IDLE) begin
			if (cmd_go) begin
				op_q <= itss_op_t'(AVS_WRITEDATA[1:0]);
				rdata_q <= 24'h00_0000;
				nack_q <= 1'b0;
				step_q <= 4'h0;
				st_q <= H_FETCH;
			end
		end else if (st_q == H_FETCH) begin
			ph_q <= 2'h0;
			bit_q <= 4'h0;
			sh_q <= it.val;
			rdm_q <= it.kind == IT_RDACK || it.kind == IT_RDNAK;
			ackd_q <= it.kind == IT_RDACK;
			case (it.kind)
				IT_START: st_q <= H_START;
				IT_STOP: st_q <= H_STOP;
				default: st_q <= H_BIT;
			endcase
		end else if (tick) begin
			ph_q <= ph_q + 2'h1;
			case (st_q)
				H_START: begin
					if (ph_q == 2'h0) sdo_q <= 1'b1;
					if (ph_q == 2'h1) scl_q <= 1'b1;
					if (ph_q == 2'h2) sdo_q <= 1'b0;
					if (ph_q == 2'h3) begin
						scl_q <= 1'b0;
						step_q <= step_q + 4'h1;
						st_q <= H_FETCH;
					end
				end
				H_BIT: begin
					if (ph_q == 2'h0) begin
						if (bit_q < ITSS_BIT_LAST) begin
							sdo_q <= rdm_q | sh_q[7];
						end else begin
							sdo_q <= ~(rdm_q & ackd_q);
						end
					end
					if (ph_q == 2'h1) scl_q <= 1'b1;
					if (ph_q == 2'h2) begin
						if (bit_q < ITSS_BIT_LAST) begin
							sh_q <= {sh_q[6:0], sda_f};
						end else if (!rdm_q && sda_f) begin
							nack_q <= 1'b1;
						end
					end
					if (ph_q == 2'h3) begin
						scl_q <= 1'b0;
						if (bit_q == ITSS_BIT_LAST) begin
							if (rdm_q) begin
								rdata_q <= {rdata_q[15:0], sh_q};
							end
							step_q <= step_q + 4'h1;
							st_q <= (nack_q && !rdm_q) ? H_STOP : H_FETCH;
						end else begin
							bit_q <= bit_q + 4'h1;
						end
					end
				end
				default: begin
					if (ph_q == 2'h0) sdo_q <= 1'b0;
					if (ph_q == 2'h1) scl_q <= 1'b1;
					if (ph_q == 2'h2) sdo_q <= 1'b1;
					if (ph_q == 2'h3) st_q <= H_IDLE;
				end
			endcase
		end
	end

	assign BUS.scl = scl_q;
	assign BUS.sda_host_o = 1'b0;
	assign BUS.sda_host_oe_n = sdo_q;
endmodule

// ### itss_if.sv
// two-wire link between the controller and the timer slave
`timescale 1ns/1ns
interface itss_if;
	logic scl;
	logic sda_dev_o;
	logic sda_dev_oe_n;
	logic sda_host_o;
	logic sda_host_oe_n;
	logic sda;
	// wired-and of both open-drain drivers with pull-up
	assign sda = ~((~sda_dev_oe_n & ~sda_dev_o) |
		(~sda_host_oe_n & ~sda_host_o));
	modport dev (
		input scl,
		input sda,
		output sda_dev_o,
		output sda_dev_oe_n
	);
	modport host (
		output scl,
		input sda,
		output sda_host_o,
		output sda_host_oe_n
	);
endinterface

// ### itss_pkg.sv
// shared constants and types for the interval timer serial slave link
package itss_pkg;
	// ========================================
	// slave side constants
	localparam logic [6:0] ITSS_SLAVE_ADDR = 7'h32;
	localparam logic [2:0] ITSS_CLR_CODE = 3'h2;
	localparam logic [7:0] ITSS_FILL_BYTE = 8'hff;
	localparam logic ITSS_PTR_CNT = 1'b1;
	localparam logic ITSS_PTR_SET = 1'b0;
	localparam int ITSS_PTR_BIT = 7;
	localparam logic [15:0] ITSS_SET_RST = 16'h0000;
	localparam logic [23:0] ITSS_SNAP_RST = 24'h00_0000;
	localparam logic [2:0] ITSS_CNT_LAST = 3'h2;
	localparam logic [2:0] ITSS_SET_LAST = 3'h1;
	localparam logic [3:0] ITSS_BIT_LAST = 4'h8;
	localparam logic [3:0] ITSS_ACK_LAST = 4'h9;
	// dummy bytes: pointer bit in bit 7, test bit 0 set
	localparam logic [7:0] ITSS_DUMMY_SET = 8'h01;
	localparam logic [7:0] ITSS_DUMMY_CNT = 8'h81;
	// ========================================
	// controller register map, word addresses
	localparam logic [2:0] ITSS_REG_CMD = 3'h0;
	localparam logic [2:0] ITSS_REG_DATA = 3'h1;
	localparam logic [2:0] ITSS_REG_STAT = 3'h2;
	localparam logic [2:0] ITSS_REG_RDATA = 3'h3;
	localparam int ITSS_STAT_BUSY = 0;
	localparam int ITSS_STAT_NACK = 1;
	// ========================================
	// timing
	localparam int ITSS_SYS_NS = 50;
	localparam int ITSS_QTR_NS = 2500;
	localparam int ITSS_QTR_CYC = (ITSS_QTR_NS + ITSS_SYS_NS - 1) / ITSS_SYS_NS;
	// ========================================
	// types
	typedef enum logic [1:0] {
		D_IDLE = 2'b00,
		D_ADDR = 2'b01,
		D_WRITE = 2'b10,
		D_READ = 2'b11
	} itss_dst_t;
	typedef enum logic [1:0] {
		OP_WRITE = 2'b00,
		OP_RCNT = 2'b01,
		OP_RSET = 2'b10
	} itss_op_t;
	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_FETCH = 3'b001,
		H_START = 3'b010,
		H_BIT = 3'b011,
		H_STOP = 3'b100
	} itss_hst_t;
	typedef enum logic [2:0] {
		IT_START = 3'b000,
		IT_WR = 3'b001,
		IT_RDACK = 3'b010,
		IT_RDNAK = 3'b011,
		IT_STOP = 3'b100
	} itss_item_t;
	typedef struct packed {
		itss_item_t kind;
		logic [7:0] val;
	} itss_step_t;
endpackage

// ### itss_properties.sv
// link and slave pin checks for the interval timer serial link
`timescale 1ns/1ns
module itss_properties (
	input wire logic CLK_SYS,
	input wire logic NRST,
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_dev_oe_n,
	input wire logic sda_host_oe_n,
	input wire logic OUTPUT_GATE,
	input wire logic [9:0] DIV_TAPS,
	input wire logic [9:0] INTERVAL_SELECT,
	input wire logic TIMER_CLEAR,
	input wire logic INTERVAL_OUT
);
	logic and_taps;
	// ========================================
	// helpers
	// and over selected taps, unselected ones read as one
	assign and_taps = &(DIV_TAPS | ~INTERVAL_SELECT);
	default clocking dcb @(posedge CLK_SYS);
	endclocking
	default disable iff (!NRST);
	// ========================================
	// link timing
	// device drives low
	dev_drive_low_a: assert property ($fell(sda_dev_oe_n) |-> !scl)
		else $error("device pulled data with clock high");
	dev_hold_bound_a: assert property (
		$fell(sda_dev_oe_n) |-> ##[1:400] sda_dev_oe_n)
		else $error("device held data line too long");
	host_sda_scl_a: assert property (
		$changed(sda_host_oe_n) |-> $stable(scl))
		else $error("host moved data and clock together");
	scl_high_time_a: assert property ($rose(scl) |-> scl[*8])
		else $error("clock high phase too short");
	// ========================================
	// slave pins
	// clear is one pulse
	clear_pulse_a: assert property (TIMER_CLEAR |=> !TIMER_CLEAR)
		else $error("clear pulse longer than one cycle");
	gate_low_out_a: assert property (
		(!OUTPUT_GATE)[*6] |-> INTERVAL_OUT)
		else $error("output not high with gate low");
	sel_zero_out_a: assert property (
		(OUTPUT_GATE && INTERVAL_SELECT == 10'h000)[*7] |-> !INTERVAL_OUT)
		else $error("output not low with no select");
	out_and_taps_a: assert property (
		(OUTPUT_GATE && INTERVAL_SELECT != 10'h000)[*6]
		|-> INTERVAL_OUT == $past(and_taps))
		else $error("output differs from and of taps");
	// main scenarios seen
	start_seen_c: cover property (scl && $fell(sda));
	ack_seen_c: cover property ($fell(sda_dev_oe_n));
	clear_seen_c: cover property (TIMER_CLEAR);
endmodule

// ### tb.sv
// bench: controller and timer slave joined over the two-wire link
`timescale 1ns/1ns
module tb
	import itss_pkg::*;
;
	logic CLK_SYS;
	logic NRST;
	logic [2:0] AVS_ADDRESS;
	logic AVS_READ;
	logic AVS_WRITE;
	logic [31:0] AVS_WRITEDATA;
	logic [31:0] AVS_READDATA;
	logic AVS_WAITREQUEST;
	logic OUTPUT_GATE;
	logic [23:0] COUNT_VALUE;
	logic [9:0] DIV_TAPS;
	logic [9:0] INTERVAL_SELECT;
	logic TIMER_CLEAR;
	logic INTERVAL_OUT;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	logic [31:0] lfsr_q;
	logic mon_skip;
	int num_errors = 0;
	int check_count = 0;
	int clr_cnt = 0;
	itss_if bus_if();
	// ========================================
	// design ends and checker
	itss_host #(.QTR_CYC(8)) itss_host_i (
		.CLK_SYS(CLK_SYS), .NRST(NRST), .AVS_ADDRESS(AVS_ADDRESS),
		.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
		.AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
		.AVS_WAITREQUEST(AVS_WAITREQUEST), .BUS(bus_if)
	);
	itss_dev itss_dev_i (
		.CLK_SYS(CLK_SYS), .NRST(NRST), .OUTPUT_GATE(OUTPUT_GATE),
		.COUNT_VALUE(COUNT_VALUE), .DIV_TAPS(DIV_TAPS),
		.INTERVAL_SELECT(INTERVAL_SELECT), .TIMER_CLEAR(TIMER_CLEAR),
		.INTERVAL_OUT(INTERVAL_OUT), .BUS(bus_if)
	);
	itss_properties itss_properties_i (
		.CLK_SYS(CLK_SYS), .NRST(NRST), .scl(bus_if.scl), .sda(bus_if.sda),
		.sda_dev_oe_n(bus_if.sda_dev_oe_n),
		.sda_host_oe_n(bus_if.sda_host_oe_n), .OUTPUT_GATE(OUTPUT_GATE),
		.DIV_TAPS(DIV_TAPS), .INTERVAL_SELECT(INTERVAL_SELECT),
		.TIMER_CLEAR(TIMER_CLEAR), .INTERVAL_OUT(INTERVAL_OUT)
	);
	// ========================================
	// clock and helpers
	initial begin
		CLK_SYS = 1'b0;
		forever begin
			#25 CLK_SYS = ~CLK_SYS;
		end
	end
	function automatic logic [31:0] next_rand(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0000_0000);
	endfunction
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk_word(input logic [31:0] e, input logic [31:0] m,
		input logic [31:0] got);
		check_count++;
		if ((got & m) !== (e & m)) begin
			num_errors++;
			$display("MISMATCH read data expected %h seen %h", e & m, got & m);
		end
	endtask
	task automatic chk_pin(input string nm, input logic [31:0] e,
		input logic [31:0] got);
		check_count++;
		if (got !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, got);
		end
	endtask
	// one bus cycle, held until waitrequest is seen low
	task automatic av_xfer(input logic [2:0] a, input logic wr,
		input logic [31:0] wd);
		int n;
		n = 0;
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= wd;
		AVS_WRITE <= wr;
		AVS_READ <= ~wr;
		do begin
			@(posedge CLK_SYS);
			n++;
		end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
		AVS_WRITE <= 1'b0;
		AVS_READ <= 1'b0;
		@(posedge CLK_SYS);
		if (n >= 50) begin
			num_errors++;
			$display("MISMATCH waitrequest expected 0 seen 1");
			give_verdict();
		end
	endtask
	task automatic expect_rd(input logic [2:0] a, input logic [31:0] e,
		input logic [31:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		av_xfer(a, 1'b0, 32'h0000_0000);
	endtask
	// polls busy; these reads are not compared
	task automatic run_op(input logic [1:0] op, input logic [15:0] d);
		int n;
		n = 0;
		av_xfer(ITSS_REG_DATA, 1'b1, {16'h0000, d});
		av_xfer(ITSS_REG_CMD, 1'b1, {30'h0000_0000, op});
		mon_skip = 1'b1;
		do begin
			av_xfer(ITSS_REG_STAT, 1'b0, 32'h0000_0000);
			n++;
		end while (AVS_READDATA[ITSS_STAT_BUSY] !== 1'b0 && n < 3000);
		mon_skip = 1'b0;
		if (n >= 3000) begin
			num_errors++;
			$display("MISMATCH busy expected 0 seen 1");
			give_verdict();
		end
	endtask
	// ========================================
	// result watchers
	always @(posedge CLK_SYS) begin
		if (AVS_READ === 1'b1 && AVS_WAITREQUEST === 1'b0 && !mon_skip) begin
			if (exp_q.size() == 0) begin
				num_errors++;
				$display("MISMATCH read data expected none seen %h", AVS_READDATA);
			end else begin
				chk_word(exp_q.pop_front(), msk_q.pop_front(), AVS_READDATA);
			end
		end
	end
	always @(posedge CLK_SYS) begin
		if (TIMER_CLEAR === 1'b1) begin
			clr_cnt <= clr_cnt + 1;
		end
	end
	// ========================================
	// main sequence
	initial begin
		logic [7:0] b3;
		logic [7:0] b4;
		logic [23:0] cnt;
		int exp_clr;
		exp_clr = 0;
		mon_skip = 1'b0;
		lfsr_q = 32'h72f7_c8ac;
		NRST <= 1'b0;
		AVS_ADDRESS <= 3'h0;
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
		AVS_WRITEDATA <= 32'h0000_0000;
		OUTPUT_GATE <= 1'b1;
		COUNT_VALUE <= 24'h00_0000;
		DIV_TAPS <= 10'h3ff;
		repeat (6) @(posedge CLK_SYS);
		NRST <= 1'b1;
		@(posedge CLK_SYS);
		expect_rd(ITSS_REG_STAT, 32'h0000_0000, 32'h0000_0003);
		expect_rd(3'h5, 32'h0000_0000, 32'hffff_ffff);
		chk_pin("select", 32'h0000_0000, {22'h00_0000, INTERVAL_SELECT});
		av_xfer(ITSS_REG_CMD, 1'b1, 32'h0000_0003);
		expect_rd(ITSS_REG_STAT, 32'h0000_0000, 32'h0000_0001);
		$display("test reset done");
		// every clear code, then read back and count
		for (int k = 0; k < 8; k++) begin
			repeat (16) lfsr_q = next_rand(lfsr_q);
			b3 = lfsr_q[7:0];
			b4 = {lfsr_q[15:11], k[2:0]};
			cnt = lfsr_q[31:8];
			exp_clr += (k == 2) ? 1 : 0;
			OUTPUT_GATE <= 1'b1;
			DIV_TAPS <= lfsr_q[25:16];
			COUNT_VALUE <= cnt;
			run_op(OP_WRITE, {b3, b4});
			expect_rd(ITSS_REG_STAT, 32'h0000_0000, 32'h0000_0003);
			chk_pin("select", {22'h00_0000, b3, b4[7:6]},
				{22'h00_0000, INTERVAL_SELECT});
			chk_pin("clears", exp_clr, clr_cnt);
			run_op(OP_RSET, 16'h0000);
			expect_rd(ITSS_REG_RDATA, {16'h0000, b3, b4[7:5], 2'b00, b4[2:0]},
				32'h0000_ffff);
			run_op(OP_RCNT, 16'h0000);
			expect_rd(ITSS_REG_RDATA, {8'h00, cnt}, 32'h00ff_ffff);
			$display("test pass %0d done", k);
		end
		// one byte past each register reads all ones
		run_op(OP_RCNT, 16'h0001);
		expect_rd(ITSS_REG_RDATA, {8'h00, cnt[15:0], 8'hff},
			32'h00ff_ffff);
		run_op(OP_RSET, 16'h0001);
		expect_rd(ITSS_REG_RDATA,
			{8'h00, b3, b4[7:5], 2'b00, b4[2:0], 8'hff},
			32'h00ff_ffff);
		// foreign address is not acknowledged
		run_op(OP_RCNT, 16'h0002);
		expect_rd(ITSS_REG_STAT, 32'h0000_0002, 32'h0000_0003);
		$display("test overrun and foreign address done");
		// gate low turns a setting read into counter data
		OUTPUT_GATE <= 1'b0;
		run_op(OP_RSET, 16'h0000);
		expect_rd(ITSS_REG_RDATA, {16'h0000, cnt[23:8]}, 32'h0000_ffff);
		$display("test gate low done");
		give_verdict();
	end
endmodule
